//--- rtl/iex_exec.sv
/*
 * executes one instruction per request: reads the operand, computes,
 * writes memory, accumulator, flags and program counter.
 * assumes data memory that answers the registered read address within the same cycle, and that
 * a request is offered only while reqReady is high.
 */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - watchdog clear zeroes counter, clears timeout and powerdown flags.
// - preclear pair clears only after both halves; single half only marks itself.
// - complement places inverted byte in accumulator, memory unchanged.
// - decimal adjust adds six to low nibble above nine or aux carry.
// - high nibble adjusted with internal carry, sets carry, stores to memory.
// - memory increment writes byte plus one back, zero flag only.
// - increment-to-accumulator puts byte plus one in accumulator, zero flag.
// - power-down halts, keeps data, clears watchdog, advances program counter.
// - power-down sets powerdown flag, clears timeout flag, others untouched.
// - direct jump loads program counter from instruction, no flags.
// - move copies addressed byte into accumulator.
module iex_exec (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // instruction request
    input wire logic reqValid,
    input wire iex_pkg::iex_req_s req,
    output logic reqReady,
    // wake from power-down, pin level
    input wire logic wakePin,
    // data memory read port
    output logic [7:0] memRdAddr,
    output logic memRdEn,
    input wire logic [7:0] memRdData,
    // data memory write port
    output iex_pkg::iex_memwr_s memWr,
    // architectural state
    output logic [7:0] acc,
    output logic [11:0] pc,
    output iex_pkg::iex_flags_s flags,
    output logic [7:0] watchdogCount,
    output logic halted,
    output logic preFirstFlag,
    output logic preSecondFlag,
    output logic done
);
    typedef struct packed {
        iex_pkg::iex_state_e fsm;
        iex_pkg::iex_req_s cur;
        logic [7:0] acc;
        logic [11:0] pc;
        iex_pkg::iex_flags_s flags;
        iex_pkg::iex_memwr_s memWr;
        logic [7:0] rdAddr;
        logic rdEn;
        logic ready;
        logic done;
        logic wdClear;
        logic pre1;
        logic pre2;
        logic [7:0] wdCount;
        logic wdFirst;
        logic wdSecond;
        logic wakeMeta;
        logic wakeSync;
        logic halt;
    } iex_exec_s;

    iex_exec_s st;
    iex_exec_s next_st;

    logic [7:0] aluResult;
    logic aluCarry;
    logic aluZero;
    logic [7:0] wdtCount;
    logic wdtPairDone;
    logic wdtFirst;
    logic wdtSecond;

    // operations that need the data memory operand
    function automatic logic needsOperand(input iex_pkg::iex_op_e op);
        needsOperand = !(op inside {iex_pkg::OP_WATCHDOG_CLEAR, iex_pkg::OP_WATCHDOG_PRE1,
            iex_pkg::OP_WATCHDOG_PRE2, iex_pkg::OP_POWER_DOWN, iex_pkg::OP_DIRECT_JUMP});
    endfunction : needsOperand

    iex_alu u_alu (
        .op(st.cur.op),
        .operand(memRdData),
        .acc(st.acc),
        .bitSel(st.cur.bitSel),
        .auxCarryIn(st.flags.auxCarryFlag),
        .carryIn(st.flags.carryFlag),
        .result(aluResult),
        .carryOut(aluCarry),
        .zeroOut(aluZero)
    );

    // clear requests are registered, so the watchdog acts one cycle later
    iex_watchdog u_wdt (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clearNow(st.wdClear),
        .preFirst(st.pre1),
        .preSecond(st.pre2),
        .count(wdtCount),
        .pairDone(wdtPairDone),
        .firstSeen(wdtFirst),
        .secondSeen(wdtSecond)
    );

    // sequencer and architectural updates
    always_comb begin
        next_st = st;
        next_st.memWr.we = 1'b0;
        next_st.rdEn = 1'b0;
        next_st.done = 1'b0;
        next_st.wdClear = 1'b0;
        next_st.pre1 = 1'b0;
        next_st.pre2 = 1'b0;
        next_st.wdCount = wdtCount;
        next_st.wdFirst = wdtFirst;
        next_st.wdSecond = wdtSecond;
        next_st.wakeMeta = wakePin;
        next_st.wakeSync = st.wakeMeta;
        // pair completion drops both flags in the same cycle as the counter
        if (wdtPairDone) begin
            next_st.flags.timeoutFlag = 1'b0;
            next_st.flags.powerdownFlag = 1'b0;
        end
        unique case (st.fsm)
            iex_pkg::ST_IDLE: begin
                if (reqValid) begin
                    next_st.cur = req;
                    next_st.ready = 1'b0;
                    if (needsOperand(req.op)) begin
                        next_st.rdAddr = req.addr;
                        next_st.rdEn = 1'b1;
                        next_st.fsm = iex_pkg::ST_READ;
                    end else begin
                        next_st.done = 1'b1;
                        next_st.ready = 1'b1;
                        next_st.pc = st.pc + iex_pkg::PC_STEP;
                        unique case (req.op)
                            iex_pkg::OP_WATCHDOG_CLEAR: begin
                                next_st.wdClear = 1'b1;
                                next_st.flags.timeoutFlag = 1'b0;
                                next_st.flags.powerdownFlag = 1'b0;
                            end
                            // a lone half only records itself; flags stay
                            iex_pkg::OP_WATCHDOG_PRE1: next_st.pre1 = 1'b1;
                            iex_pkg::OP_WATCHDOG_PRE2: next_st.pre2 = 1'b1;
                            iex_pkg::OP_POWER_DOWN: begin
                                next_st.wdClear = 1'b1;
                                next_st.flags.powerdownFlag = 1'b1;
                                next_st.flags.timeoutFlag = 1'b0;
                                next_st.ready = 1'b0;
                                next_st.fsm = iex_pkg::ST_HALT;
                                next_st.halt = 1'b1;
                            end
                            iex_pkg::OP_DIRECT_JUMP: next_st.pc = req.target;
                            default: next_st.pc = st.pc + iex_pkg::PC_STEP;
                        endcase
                    end
                end
            end
            iex_pkg::ST_READ: begin
                // operand arrives this cycle
                next_st.fsm = iex_pkg::ST_IDLE;
                next_st.ready = 1'b1;
                next_st.done = 1'b1;
                next_st.pc = st.pc + iex_pkg::PC_STEP;
                next_st.memWr.addr = st.cur.addr;
                next_st.memWr.data = aluResult;
                unique case (st.cur.op)
                    iex_pkg::OP_BIT_CLEAR: next_st.memWr.we = 1'b1;
                    iex_pkg::OP_COMPLEMENT_ACC: next_st.acc = aluResult;
                    iex_pkg::OP_DECIMAL_ADJUST: begin
                        next_st.memWr.we = 1'b1;
                        next_st.flags.carryFlag = aluCarry;
                    end
                    iex_pkg::OP_INC_MEM, iex_pkg::OP_DEC_MEM: begin
                        next_st.memWr.we = 1'b1;
                        next_st.flags.zeroFlag = aluZero;
                    end
                    iex_pkg::OP_INC_ACC, iex_pkg::OP_DEC_ACC: begin
                        next_st.acc = aluResult;
                        next_st.flags.zeroFlag = aluZero;
                    end
                    iex_pkg::OP_MOVE_ACC: next_st.acc = memRdData;
                    default: next_st.acc = st.acc;
                endcase
            end
            iex_pkg::ST_HALT: begin
                // execution stopped; memory and registers keep their contents
                if (st.wakeSync) begin
                    next_st.fsm = iex_pkg::ST_IDLE;
                    next_st.halt = 1'b0;
                    next_st.ready = 1'b1;
                end
            end
            default: begin
                next_st.fsm = iex_pkg::ST_IDLE;
                next_st.halt = 1'b0;
                next_st.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.fsm <= iex_pkg::ST_IDLE;
            st.pc <= iex_pkg::PC_RESET;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign reqReady = st.ready;
    assign memRdAddr = st.rdAddr;
    assign memRdEn = st.rdEn;
    assign memWr = st.memWr;
    assign acc = st.acc;
    assign pc = st.pc;
    assign flags = st.flags;
    assign watchdogCount = st.wdCount;
    assign halted = st.halt; // own flop, not a decode of the state code
    assign preFirstFlag = st.wdFirst;
    assign preSecondFlag = st.wdSecond;
    assign done = st.done;
endmodule : iex_exec
`default_nettype wire

//--- rtl/iex_pkg.sv
/*
 * shared types and constants for the instruction execution block.
 * assumes a single 100 MHz system clock and an external decoder that
 * presents one operation per request.
 */
package iex_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PC_W = 12;
    localparam int WDT_W = 8;
    localparam int PRE_W = 8;
    localparam int BIT_W = 3;

    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [WDT_W-1:0] WDT_RESET = 8'h00;
    localparam logic [PRE_W-1:0] PRE_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [PC_W-1:0] PC_STEP = 12'h001;

    // operation codes handed in by the decoder
    typedef enum logic [3:0] {
        OP_BIT_CLEAR = 4'h0,
        OP_WATCHDOG_CLEAR = 4'h1,
        OP_WATCHDOG_PRE1 = 4'h2,
        OP_WATCHDOG_PRE2 = 4'h3,
        OP_COMPLEMENT_ACC = 4'h4,
        OP_DECIMAL_ADJUST = 4'h5,
        OP_INC_MEM = 4'h6,
        OP_INC_ACC = 4'h7,
        OP_DEC_MEM = 4'h8,
        OP_DEC_ACC = 4'h9,
        OP_POWER_DOWN = 4'ha,
        OP_DIRECT_JUMP = 4'hb,
        OP_MOVE_ACC = 4'hc
    } iex_op_e;

    // execution sequencer, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_HALT = 3'b100
    } iex_state_e;

    // one instruction request
    typedef struct packed {
        iex_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [BIT_W-1:0] bitSel;
        logic [PC_W-1:0] target;
    } iex_req_s;

    // status flags
    typedef struct packed {
        logic timeoutFlag;
        logic powerdownFlag;
        logic overflowFlag;
        logic zeroFlag;
        logic auxCarryFlag;
        logic carryFlag;
    } iex_flags_s;

    // data memory write port
    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } iex_memwr_s;

endpackage : iex_pkg

//--- rtl/iex_alu.sv
/*
 * combinational datapath for the executed operations.
 * assumes the operand byte is already read from data memory.
 */
`timescale 1ns/1ps
`default_nettype none
module iex_alu (
    // operands
    input wire iex_pkg::iex_op_e op,
    input wire logic [7:0] operand,
    input wire logic [7:0] acc,
    input wire logic [2:0] bitSel,
    input wire logic auxCarryIn,
    input wire logic carryIn,
    // results
    output logic [7:0] result,
    output logic carryOut,
    output logic zeroOut
);
    logic [4:0] lowSum;
    logic [4:0] highSum;
    logic lowCarry;

    // datapath per operation
    always_comb begin
        lowSum = {1'b0, acc[3:0]};
        highSum = {1'b0, acc[7:4]};
        lowCarry = 1'b0;
        carryOut = carryIn;
        result = operand;
        unique case (op)
            iex_pkg::OP_BIT_CLEAR: result = operand & ~(iex_pkg::ONE << bitSel);
            iex_pkg::OP_COMPLEMENT_ACC: result = ~operand;
            iex_pkg::OP_INC_MEM, iex_pkg::OP_INC_ACC: result = operand + iex_pkg::ONE;
            iex_pkg::OP_DEC_MEM, iex_pkg::OP_DEC_ACC: result = operand - iex_pkg::ONE;
            iex_pkg::OP_DECIMAL_ADJUST: begin
                // low nibble: fix above nine or on aux carry
                if (acc[3:0] > iex_pkg::BCD_LIMIT || auxCarryIn) begin
                    lowSum = {1'b0, acc[3:0]} + {1'b0, iex_pkg::BCD_FIX};
                end
                lowCarry = lowSum[4];
                // internal carry joins the high nibble before the nibble is judged
                highSum = {1'b0, acc[7:4]} + {4'h0, lowCarry};
                if (highSum > {1'b0, iex_pkg::BCD_LIMIT} || carryIn) begin
                    highSum = highSum + {1'b0, iex_pkg::BCD_FIX};
                    carryOut = 1'b1;
                end else begin
                    carryOut = carryIn;
                end
                result = {highSum[3:0], lowSum[3:0]};
            end
            default: result = operand;
        endcase
        zeroOut = (result == iex_pkg::ZERO_BYTE);
    end
endmodule : iex_alu
`default_nettype wire

//--- rtl/iex_watchdog.sv
/*
 * watchdog counter with prescaler and the preclear pair tracking.
 * assumes clear requests are one-cycle pulses from the executor.
 */
`timescale 1ns/1ps
`default_nettype none
module iex_watchdog (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // requests
    input wire logic clearNow,
    input wire logic preFirst,
    input wire logic preSecond,
    // state
    output logic [7:0] count,
    output logic pairDone,
    output logic firstSeen,
    output logic secondSeen
);
    typedef struct packed {
        logic [7:0] pre;
        logic [7:0] count;
        logic first;
        logic second;
    } iex_wdt_s;

    iex_wdt_s state;
    iex_wdt_s next_state;
    logic bothDone;

    // pair completes when the other half is already recorded
    always_comb begin
        next_state = state;
        bothDone = (preFirst && state.second) || (preSecond && state.first);
        if (preFirst) next_state.first = 1'b1;
        if (preSecond) next_state.second = 1'b1;
        next_state.pre = state.pre + 8'h01;
        if (&state.pre) next_state.count = state.count + 8'h01;
        if (clearNow || bothDone) begin
            next_state.pre = iex_pkg::PRE_RESET;
            next_state.count = iex_pkg::WDT_RESET;
            next_state.first = 1'b0;
            next_state.second = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign count = state.count;
    assign pairDone = bothDone;
    assign firstSeen = state.first;
    assign secondSeen = state.second;
endmodule : iex_watchdog
`default_nettype wire

//--- tb/iex_mem_model.sv
/*
 * data memory model on the far side of the execution block.
 * assumes reads and writes are launched from clk_sys edges.
 */
`timescale 1ns/1ps
`default_nettype none
module iex_mem_model (
    // clock
    input wire logic clk_sys,
    // read port
    input wire logic [7:0] memRdAddr,
    input wire logic memRdEn,
    output logic [7:0] memRdData,
    // write port
    input wire iex_pkg::iex_memwr_s memWr
);
    logic [7:0] mem [256];
    // preset: byte is address xor a5, the bench mirrors this
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'ha5;
        end
    end
    // the registered address is answered within its own cycle; with the
    // enable low the port shows the inverse, so a mistimed sample fails
    assign memRdData = memRdEn ? mem[memRdAddr] : ~mem[memRdAddr];
    always @(posedge clk_sys) begin
        if (memWr.we) begin
            mem[memWr.addr] <= memWr.data;
        end
    end
endmodule : iex_mem_model
`default_nettype wire

//--- tb/iex_exec_assertions.sv
/*
 * port-level checks of the execution block.
 * assumes one clock domain and requests that never overlap.
 */
`timescale 1ns/1ps
`default_nettype none
module iex_exec_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // request
    input wire logic reqValid,
    input wire iex_pkg::iex_req_s req,
    input wire logic reqReady,
    // memory
    input wire logic memRdEn,
    input wire logic [7:0] memRdAddr,
    input wire logic [7:0] memRdData,
    input wire iex_pkg::iex_memwr_s memWr,
    // state
    input wire logic [7:0] acc,
    input wire logic [11:0] pc,
    input wire iex_pkg::iex_flags_s flags,
    input wire logic [7:0] watchdogCount,
    input wire logic halted,
    input wire logic done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic take;
    iex_pkg::iex_op_e lastOp;
    assign take = reqValid && reqReady;
    // op in flight, needed to judge the done cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lastOp <= iex_pkg::OP_BIT_CLEAR;
        end else if (take) begin
            lastOp <= req.op;
        end
    end
    property p_rd_done;
        memRdEn |-> !reqReady ##1 done;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("no done after read");
    property p_jump;
        take && req.op == iex_pkg::OP_DIRECT_JUMP |=> pc == $past(req.target);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target lost");
    property p_halt;
        take && req.op == iex_pkg::OP_POWER_DOWN |=> halted && flags.powerdownFlag
            && !flags.timeoutFlag && pc == $past(pc) + 12'h001;
    endproperty
    a_halt: assert property (p_halt) else $error("bad power-down entry");
    property p_wd_clr;
        take && req.op == iex_pkg::OP_WATCHDOG_CLEAR |=> !flags.timeoutFlag
            && !flags.powerdownFlag ##2 watchdogCount == 8'h00;
    endproperty
    a_wd_clr: assert property (p_wd_clr) else $error("watchdog clear failed");
    property p_halt_keep;
        halted && $past(halted) |-> $stable(acc) && $stable(pc) && !memWr.we;
    endproperty
    a_halt_keep: assert property (p_halt_keep) else $error("state moved in halt");
    property p_cpl;
        done && lastOp == iex_pkg::OP_COMPLEMENT_ACC |-> acc == ~$past(memRdData) && !memWr.we;
    endproperty
    a_cpl: assert property (p_cpl) else $error("complement wrong");
    property p_move;
        done && lastOp == iex_pkg::OP_MOVE_ACC |-> acc == $past(memRdData);
    endproperty
    a_move: assert property (p_move) else $error("move wrong");
    property p_inc_mem;
        done && lastOp == iex_pkg::OP_INC_MEM |-> memWr.we
            && memWr.data == $past(memRdData) + 8'h01 && memWr.addr == $past(memRdAddr);
    endproperty
    a_inc_mem: assert property (p_inc_mem) else $error("increment wrong");
endmodule : iex_exec_assertions
bind iex_exec iex_exec_assertions chk_u (.clk_sys, .reset_n, .reqValid, .req, .reqReady,
    .memRdEn, .memRdAddr, .memRdData, .memWr, .acc, .pc, .flags, .watchdogCount,
    .halted, .done);
`default_nettype wire

//--- tb/tb_top.sv
/*
 * self-checking bench for the execution block.
 * assumes the memory model presets each byte to address xor a5.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic reqValid = 1'b0;
    logic wakePin = 1'b0;
    iex_pkg::iex_req_s req = '0;
    logic reqReady, memRdEn, halted, preFirstFlag, preSecondFlag, done;
    logic [7:0] memRdAddr, memRdData, acc, watchdogCount;
    logic [11:0] pc, prevPc;
    logic [8:0] adj;
    logic [7:0] daaSrc [3] = '{8'h9a, 8'ha9, 8'h12};
    iex_pkg::iex_memwr_s memWr;
    iex_pkg::iex_flags_s flags, prevFlags, expFlags;
    int errors = 0;
    int n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    iex_exec dut_u (.clk_sys, .reset_n, .reqValid, .req, .reqReady, .wakePin, .memRdAddr,
        .memRdEn, .memRdData, .memWr, .acc, .pc, .flags, .watchdogCount, .halted,
        .preFirstFlag, .preSecondFlag, .done);
    iex_mem_model mem_u (.clk_sys, .memRdAddr, .memRdEn, .memRdData, .memWr);
    task automatic conclude();
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one request, held until taken, then wait for done
    task automatic run(input iex_pkg::iex_op_e op, input logic [7:0] a, input logic [2:0] b,
        input logic [11:0] t);
        int k;
        prevFlags = flags;
        prevPc = pc;
        @(posedge clk_sys);
        reqValid <= 1'b1;
        req <= '{op, a, b, t};
        k = 0;
        do begin @(posedge clk_sys); k++; end while (reqReady !== 1'b1 && k < 64);
        reqValid <= 1'b0;
        do begin @(negedge clk_sys); k++; end while (done !== 1'b1 && k < 128);
        if (k >= 128) begin errors++; conclude(); end
    endtask : run
    task automatic wake();
        int k;
        @(posedge clk_sys);
        wakePin <= 1'b1;
        k = 0;
        do begin @(negedge clk_sys); k++; end while (reqReady !== 1'b1 && k < 64);
        @(posedge clk_sys);
        wakePin <= 1'b0;
        if (k >= 64) begin errors++; conclude(); end
    endtask : wake
    // flags unchanged except zero
    task automatic fz(input logic z);
        expFlags = prevFlags;
        expFlags.zeroFlag = z;
        chk(17'(flags), 17'(expFlags));
    endtask : fz
    // expected adjust as {carry, byte}; aux carry stays clear
    function automatic logic [8:0] daa(input logic [7:0] a, input logic c);
        logic [4:0] lo;
        logic [4:0] hi;
        logic fixHi;
        lo = {1'b0, a[3:0]} + ((a[3:0] > 4'h9) ? 5'h06 : 5'h00);
        hi = {1'b0, a[7:4]} + {4'h0, lo[4]};
        fixHi = (hi > 5'h09) || c;
        hi = hi + (fixHi ? 5'h06 : 5'h00);
        return {c | fixHi, hi[3:0], lo[3:0]};
    endfunction : daa
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        // move then adjust: low fix, high fix, carry-forced fix
        foreach (daaSrc[i]) begin
            run(iex_pkg::OP_MOVE_ACC, daaSrc[i] ^ 8'ha5, 3'h0, 12'h000);
            chk(17'(acc), 17'(daaSrc[i]));
            adj = daa(daaSrc[i], flags.carryFlag);
            run(iex_pkg::OP_DECIMAL_ADJUST, 8'h20, 3'h0, 12'h000);
            chk({memWr.we, memWr.addr, memWr.data}, {1'b1, 8'h20, adj[7:0]});
            expFlags = prevFlags;
            expFlags.carryFlag = adj[8];
            chk(17'(flags), 17'(expFlags));
        end
        // wrap to zero and back in memory; accumulator forms go 00 to 01 and 01 to 00
        run(iex_pkg::OP_INC_MEM, 8'h5a, 3'h0, 12'h000);
        chk({memWr.we, memWr.addr, memWr.data}, {1'b1, 8'h5a, 8'h00});
        fz(1'b1);
        run(iex_pkg::OP_INC_ACC, 8'ha5, 3'h0, 12'h000);
        chk(17'({memWr.we, acc}), 17'h00001);
        fz(1'b0);
        run(iex_pkg::OP_DEC_MEM, 8'ha5, 3'h0, 12'h000);
        chk({memWr.we, memWr.addr, memWr.data}, {1'b1, 8'ha5, 8'hff});
        fz(1'b0);
        run(iex_pkg::OP_DEC_ACC, 8'ha4, 3'h0, 12'h000);
        chk(17'({memWr.we, acc}), 17'h00000);
        fz(1'b1);
        run(iex_pkg::OP_COMPLEMENT_ACC, 8'h01, 3'h0, 12'h000);
        chk(17'({memWr.we, acc}), 17'h0005b);
        chk(17'(flags), 17'(prevFlags));
        for (int b = 0; b < 8; b++) begin
            run(iex_pkg::OP_BIT_CLEAR, 8'h10 + 8'(b), 3'(b), 12'h000);
            chk({memWr.we, memWr.addr, memWr.data}, {1'b1, 8'h10 + 8'(b),
                ((8'h10 + 8'(b)) ^ 8'ha5) & ~(8'h01 << b)});
            chk(17'(flags), 17'(prevFlags));
        end
        run(iex_pkg::OP_DIRECT_JUMP, 8'h00, 3'h0, 12'habc);
        chk(17'(pc), 17'h00abc);
        chk(17'(flags), 17'(prevFlags));
        // let the watchdog run, then power down
        repeat (600) @(negedge clk_sys);
        chk(17'(watchdogCount != 8'h00), 17'h1);
        run(iex_pkg::OP_POWER_DOWN, 8'h00, 3'h0, 12'h000);
        chk(17'({halted, reqReady, pc}), 17'({2'b10, prevPc + 12'h001}));
        expFlags = prevFlags;
        expFlags.powerdownFlag = 1'b1;
        expFlags.timeoutFlag = 1'b0;
        chk(17'(flags), 17'(expFlags));
        repeat (3) @(negedge clk_sys);
        chk(17'(watchdogCount), 17'h0);
        wake();
        // preclear pair: one half marks only, both clear
        run(iex_pkg::OP_WATCHDOG_PRE1, 8'h00, 3'h0, 12'h000);
        repeat (3) @(negedge clk_sys);
        chk(17'({preFirstFlag, flags.powerdownFlag}), 17'h3);
        run(iex_pkg::OP_WATCHDOG_PRE2, 8'h00, 3'h0, 12'h000);
        repeat (3) @(negedge clk_sys);
        chk(17'(flags.powerdownFlag), 17'h0);
        // a plain clear discards a pending half
        run(iex_pkg::OP_POWER_DOWN, 8'h00, 3'h0, 12'h000);
        wake();
        run(iex_pkg::OP_WATCHDOG_PRE2, 8'h00, 3'h0, 12'h000);
        run(iex_pkg::OP_WATCHDOG_CLEAR, 8'h00, 3'h0, 12'h000);
        repeat (3) @(negedge clk_sys);
        chk(17'({preSecondFlag, flags.powerdownFlag, flags.timeoutFlag}), 17'h0);
        run(iex_pkg::OP_POWER_DOWN, 8'h00, 3'h0, 12'h000);
        wake();
        run(iex_pkg::OP_WATCHDOG_PRE1, 8'h00, 3'h0, 12'h000);
        repeat (3) @(negedge clk_sys);
        chk(17'(flags.powerdownFlag), 17'h1);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
